// ===== design/dsr_pkg.sv
// package: status register map, field positions and engine states
package dsr_pkg;
  localparam logic [7:0]  STATUS_OFS      = 8'h04;
  localparam logic [7:0]  BTT_OFS         = 8'h28;
  localparam logic [7:0]  TAIL_OFS        = 8'h10;
  localparam int          RSVD0_BIT       = 0;
  localparam int          IDLE_BIT        = 1;
  localparam int          RSVD2_BIT       = 2;
  localparam int          SG_INCL_BIT     = 3;
  localparam int          INT_ERR_BIT     = 4;
  localparam int          SLV_ERR_BIT     = 5;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
  localparam logic [3:0]  DRAIN_CYCLES    = 4'h4;
  localparam logic [3:0]  DRAIN_ZERO      = 4'h0;
  localparam logic        IDLE_RESET      = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_BUSY  = 4'b0010,
    ST_DRAIN = 4'b0100,
    ST_HALT  = 4'b1000
  } dsr_state_t;
endpackage : dsr_pkg

// ===== design/dsr_halt_timer.sv
// module: drain counter used for graceful shutdown
`timescale 1ns/1ps
module dsr_halt_timer (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // control
  input  wire logic       start_i,
  output logic            done_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       run;
  } dsr_tmr_t;

  dsr_tmr_t st_r;
  dsr_tmr_t st_nxt;

  // count down from load, flag completion
  always_comb begin
    st_nxt = st_r;
    if (start_i) begin
      st_nxt.cnt = dsr_pkg::DRAIN_CYCLES;
      st_nxt.run = 1'b1;
    end else if (st_r.run && st_r.cnt != dsr_pkg::DRAIN_ZERO) begin
      st_nxt.cnt = st_r.cnt - 4'h1;
    end else begin
      st_nxt.run = 1'b0;
    end
  end

  assign done_o = st_r.run && (st_r.cnt == dsr_pkg::DRAIN_ZERO);

  // state register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end
endmodule // dsr_halt_timer

// ===== design/dsr_status.sv
// module: dma engine status register and idle/error tracking
// How it works
// - bit 0 reserved, always reads zero
// - simple mode: idle set once programmed transfer finishes
// - simple mode: byte-count write leaves idle, clears idle bit
// - sg mode: idle set when tail reached, all descriptors done
// - sg mode: tail pointer write restarts descriptor processing
// - bit 3 shows whether scatter-gather support was built in
// - bit 4 set on mover internal error
// - zero byte count, written or fetched, raises internal error
// - on internal error halt gracefully, idle only after shutdown
// - error flags stay until soft or hard reset
// - bit 5 set on slave error response, then graceful halt
`timescale 1ns/1ps
module dsr_status #(
  parameter bit SG_BUILD_OPTION = 1'b1
) (
  // clock, enable, resets
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        soft_rst_i,
  // mode select, 1 = scatter-gather
  input  wire logic        sg_mode_i,
  // register access
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic [31:0]      reg_rdata_o,
  // mover and descriptor engine events
  input  wire logic        xfer_done_i,
  input  wire logic        desc_fetch_i,
  input  wire logic [25:0] desc_btt_i,
  input  wire logic        tail_reached_i,
  input  wire logic        mover_int_err_i,
  input  wire logic        slave_err_i,
  // engine control outputs
  output logic             xfer_start_o,
  output logic             sg_restart_o,
  output logic             halt_req_o,
  output logic             engine_idle_flag_o
);
  // block state, except the drain counter held in u_halt, in one register
  typedef struct packed {
    dsr_pkg::dsr_state_t state;
    logic                int_err;
    logic                slv_err;
    logic [31:0]         rdata;
    logic                start;
    logic                restart;
  } dsr_st_t;

  // registered state and its next value
  dsr_st_t     st_r;
  dsr_st_t     st_nxt;

  // shutdown timer handshake
  logic        drain_start;
  logic        drain_done;

  // register window decode
  logic        addr_btt;
  logic        addr_tail;
  logic        addr_status;
  logic        rd_status;
  logic        btt_wr;
  logic        tail_wr;
  logic        sg_ok;

  // error causes
  logic        wr_zero;
  logic        fetch_zero;
  logic        zero_cnt;
  logic        int_err_ev;
  logic        err_now;

  // state decode and status word
  logic        in_idle;
  logic        in_drain;
  logic        in_halt;
  logic        idle_bit;
  logic [31:0] status_word;

  // shutdown timing
  dsr_halt_timer u_halt (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .start_i   (drain_start),
    .done_o    (drain_done)
  );

  // address decode of the register window
  assign addr_btt    = reg_addr_i == dsr_pkg::BTT_OFS;
  assign addr_tail   = reg_addr_i == dsr_pkg::TAIL_OFS;
  assign addr_status = reg_addr_i == dsr_pkg::STATUS_OFS;
  assign rd_status   = reg_rd_i && addr_status;

  // writes to the other mode's start register are ignored
  assign sg_ok   = SG_BUILD_OPTION && sg_mode_i;
  assign btt_wr  = reg_wr_i && addr_btt && !sg_ok;
  assign tail_wr = reg_wr_i && addr_tail && sg_ok;

  // zero byte count, written or fetched, is an internal error
  assign wr_zero    = btt_wr && reg_wdata_i == dsr_pkg::ZERO_WORD;
  assign fetch_zero = desc_fetch_i && sg_ok && desc_btt_i == '0;
  assign zero_cnt   = wr_zero || fetch_zero;
  assign int_err_ev = zero_cnt || mover_int_err_i;
  assign err_now    = int_err_ev || slave_err_i;

  // one-hot state decode; a halted engine reads as idle
  assign in_idle  = st_r.state == dsr_pkg::ST_IDLE;
  assign in_drain = st_r.state == dsr_pkg::ST_DRAIN;
  assign in_halt  = st_r.state == dsr_pkg::ST_HALT;
  assign idle_bit = in_idle || in_halt;

  // next-state logic
  always_comb begin
    // start pulses last one cycle unless raised again
    st_nxt         = st_r;
    st_nxt.start   = 1'b0;
    st_nxt.restart = 1'b0;
    drain_start    = 1'b0;

    // internal error flag, cleared only by reset
    if (int_err_ev) begin
      st_nxt.int_err = 1'b1;
    end

    // slave error flag, cleared only by reset
    if (slave_err_i) begin
      st_nxt.slv_err = 1'b1;
    end

    // engine state walk; an error wins over any start
    case (st_r.state)
      // idle: waits for a byte-count or tail write
      dsr_pkg::ST_IDLE: begin
        if (err_now) begin
          st_nxt.state = dsr_pkg::ST_DRAIN;
          drain_start  = 1'b1;
        end else if (btt_wr) begin
          st_nxt.state = dsr_pkg::ST_BUSY;
          st_nxt.start = 1'b1;
        end else if (tail_wr) begin
          st_nxt.state   = dsr_pkg::ST_BUSY;
          st_nxt.restart = 1'b1;
        end
      end

      // busy: runs until done, tail or error
      dsr_pkg::ST_BUSY: begin
        if (err_now) begin
          st_nxt.state = dsr_pkg::ST_DRAIN;
          drain_start  = 1'b1;
        end else if (!sg_ok && xfer_done_i) begin
          st_nxt.state = dsr_pkg::ST_IDLE;
        end else if (sg_ok && tail_reached_i) begin
          st_nxt.state = dsr_pkg::ST_IDLE;
        end else if (tail_wr) begin
          st_nxt.restart = 1'b1;
        end
      end

      // drain: fixed shutdown wait, then halt
      dsr_pkg::ST_DRAIN: begin
        if (drain_done) begin
          st_nxt.state = dsr_pkg::ST_HALT;
        end
      end

      // halt: reads as idle until a reset
      dsr_pkg::ST_HALT: begin
        st_nxt.state = dsr_pkg::ST_HALT;
      end

      // stray codes park in halt
      default: begin
        st_nxt.state = dsr_pkg::ST_HALT;
      end
    endcase

    // status word as software sees it, reserved bits held low
    status_word                       = dsr_pkg::ZERO_WORD;
    status_word[dsr_pkg::RSVD0_BIT]   = 1'b0;
    status_word[dsr_pkg::IDLE_BIT]    = idle_bit;
    status_word[dsr_pkg::RSVD2_BIT]   = 1'b0;
    status_word[dsr_pkg::SG_INCL_BIT] = SG_BUILD_OPTION;
    status_word[dsr_pkg::INT_ERR_BIT] = st_r.int_err;
    status_word[dsr_pkg::SLV_ERR_BIT] = st_r.slv_err;
    // read data stands one cycle after a status read
    if (rd_status) begin
      st_nxt.rdata = status_word;
    end else begin
      st_nxt.rdata = dsr_pkg::ZERO_WORD;
    end
  end

  // outputs
  assign reg_rdata_o        = st_r.rdata;
  assign xfer_start_o       = st_r.start;
  assign sg_restart_o       = st_r.restart;
  assign halt_req_o         = in_drain || in_halt;
  assign engine_idle_flag_o = idle_bit;

  // state register; soft reset clears errors and returns to idle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // idle, flags clear, no pulses
      st_r       <= '0;
      st_r.state <= dsr_pkg::ST_IDLE;
    end else if (ce_i) begin
      // soft reset acts on the same edge that samples it, when enabled
      if (soft_rst_i) begin
        st_r       <= '0;
        st_r.state <= dsr_pkg::ST_IDLE;
      end else begin
        st_r <= st_nxt;
      end
    end
  end
endmodule // dsr_status

// ===== sim/dsr_status_asserts.sv
// checker: status port assertions
`timescale 1ns/1ps
module dsr_chk #(
  parameter bit SG_BUILD_OPTION = 1'b1
) (
  // clock, enable and resets
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        soft_rst_i,
  // mode and register access
  input  wire logic        sg_mode_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  // error events
  input  wire logic        mover_int_err_i,
  input  wire logic        slave_err_i,
  // watched outputs
  input  wire logic [31:0] reg_rdata_o,
  input  wire logic        xfer_start_o,
  input  wire logic        halt_req_o,
  input  wire logic        engine_idle_flag_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // accepted events and byte-count writes
  wire go = ce_i & !soft_rst_i & !halt_req_o;
  wire bw = go & reg_wr_i & (reg_addr_i == dsr_pkg::BTT_OFS)
    & !(sg_mode_i & SG_BUILD_OPTION) & engine_idle_flag_o;
  wire bz = reg_wdata_i == dsr_pkg::ZERO_WORD;
  a_bit0_zero: assert property (!reg_rdata_o[0])
    else $error("bit0 set");
  a_bit2_zero: assert property (!reg_rdata_o[2])
    else $error("bit2 set");
  a_sg_bit: assert property (ce_i && reg_rd_i && reg_addr_i ==
    dsr_pkg::STATUS_OFS |=> reg_rdata_o[3] == SG_BUILD_OPTION)
    else $error("sg bit");
  a_start_clr: assert property (bw && !bz |=>
    xfer_start_o && !engine_idle_flag_o) else $error("no start");
  a_zero_btt: assert property (bw && bz |=>
    halt_req_o && !xfer_start_o) else $error("zero count");
  a_int_err: assert property (go && mover_int_err_i |=>
    halt_req_o && !engine_idle_flag_o) else $error("int err");
  a_halt_idle: assert property ($rose(halt_req_o) |->
    !engine_idle_flag_o [*5] ##1 engine_idle_flag_o) else $error("drain");
  a_slv_err: assert property (go && slave_err_i |=>
    halt_req_o ##5 engine_idle_flag_o) else $error("slave err");
  a_err_sticky: assert property (halt_req_o && ce_i &&
    !soft_rst_i |=> halt_req_o) else $error("sticky");
endmodule // dsr_chk
bind dsr_status dsr_chk #(.SG_BUILD_OPTION(SG_BUILD_OPTION)) chk_u (
  .sys_clk_i, .rst_i, .ce_i, .soft_rst_i, .sg_mode_i, .reg_wr_i,
  .reg_rd_i, .mover_int_err_i, .slave_err_i, .reg_addr_i, .reg_wdata_i,
  .reg_rdata_o, .xfer_start_o, .halt_req_o, .engine_idle_flag_o);

// ===== sim/dsr_far.sv
// partner: mover and descriptor engine event model
`timescale 1ns/1ps
module dsr_far (
  // clock and engine requests
  input  wire logic   sys_clk_i,
  input  wire logic   start_i,
  input  wire logic   restart_i,
  input  wire logic   zero_i,
  // events back to the status block
  output logic        done_o  = 1'h0,
  output logic        fetch_o = 1'h0,
  output logic        tail_o  = 1'h0,
  output logic [25:0] btt_o   = 26'h0
);
  logic [2:0] cnt_r = 3'h0;
  logic       sg_r = 1'h0;
  // answer after a few cycles; count toggles outside a fetch
  always @(posedge sys_clk_i) begin
    done_o  <= cnt_r == 3'h1 && !sg_r;
    fetch_o <= cnt_r == 3'h2 && sg_r;
    tail_o  <= cnt_r == 3'h1 && sg_r;
    btt_o   <= cnt_r == 3'h2 ? (zero_i ? 26'h0 : 26'h40) : ~btt_o;
    if (start_i || restart_i) {cnt_r, sg_r} <= {3'h4, restart_i};
    else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
  end
endmodule // dsr_far

// ===== sim/dsr_status_bench.sv
// bench: status register tests
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected %s exp %h got %h", n, e, g); end end
module dsr_status_bench;
  logic        sys_clk_i = 0, rst_i = 1, ce_i = 1, soft_rst_i = 0, zd = 0;
  logic        sg_mode_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic        mover_int_err_i = 0, slave_err_i = 0;
  logic [7:0]  reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o;
  logic        xfer_done_i, desc_fetch_i, tail_reached_i, xfer_start_o;
  logic        sg_restart_o, halt_req_o, engine_idle_flag_o;
  logic [25:0] desc_btt_i;
  int          n_mismatch = 0, cmp_count = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  dsr_status dut_u (.sys_clk_i, .rst_i, .ce_i, .soft_rst_i, .sg_mode_i,
    .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .xfer_done_i, .desc_fetch_i, .desc_btt_i, .tail_reached_i,
    .mover_int_err_i, .slave_err_i, .xfer_start_o, .sg_restart_o,
    .halt_req_o, .engine_idle_flag_o);
  dsr_far far_u (.sys_clk_i, .start_i(xfer_start_o), .zero_i(zd),
    .restart_i(sg_restart_o), .done_o(xfer_done_i), .tail_o(tail_reached_i),
    .fetch_o(desc_fetch_i), .btt_o(desc_btt_i));
  // register strobes and event pulses
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'h1, a, d};
    @(posedge sys_clk_i) reg_wr_i <= 1'h0;
  endtask
  task st(input logic [31:0] e);
    @(posedge sys_clk_i) {reg_rd_i, reg_addr_i} <= {1'h1, dsr_pkg::STATUS_OFS};
    @(posedge sys_clk_i) reg_rd_i <= 1'h0;
    #1 `CHK("status", e, reg_rdata_o)
  endtask
  task pl(input bit s);
    @(posedge sys_clk_i) {slave_err_i, mover_int_err_i} <= {s, !s};
    @(posedge sys_clk_i) {slave_err_i, mover_int_err_i} <= 2'h0;
  endtask
  task await(input bit h);
    #1;
    repeat (20) if ((h ? halt_req_o : engine_idle_flag_o) !== 1'h1)
      @(posedge sys_clk_i) #1;
    `CHK("wait", 1'h1, h ? halt_req_o : engine_idle_flag_o)
  endtask
  task tally_and_finish;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    st(32'h0000_000A);
    wr(dsr_pkg::STATUS_OFS, 32'hFFFF_FFFF);
    st(32'h0000_000A);
    // a write while the clock enable is low must not start the engine
    @(posedge sys_clk_i) ce_i <= 1'h0;
    wr(dsr_pkg::BTT_OFS, 32'h0000_0040);
    @(posedge sys_clk_i) ce_i <= 1'h1;
    st(32'h0000_000A);
    wr(dsr_pkg::BTT_OFS, 32'h0000_0040);
    st(32'h0000_0008);
    await(0);
    st(32'h0000_000A);
    @(posedge sys_clk_i) sg_mode_i <= 1'h1;
    wr(dsr_pkg::TAIL_OFS, 32'h0000_0100);
    st(32'h0000_0008);
    await(0);
    st(32'h0000_000A);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i) {sg_mode_i, zd} <= {2{k == 3}};
      if (k == 0) wr(dsr_pkg::BTT_OFS, 32'h0000_0000);
      else if (k == 3) wr(dsr_pkg::TAIL_OFS, 32'h0000_0100);
      else pl(k == 2);
      await(1);
      st({26'h0, k == 2, k != 2, 4'h8});
      await(0);
      st({26'h0, k == 2, k != 2, 4'hA});
      @(posedge sys_clk_i) soft_rst_i <= 1'h1;
      @(posedge sys_clk_i) soft_rst_i <= 1'h0;
      st(32'h0000_000A);
    end
    tally_and_finish;
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    n_mismatch++;
    tally_and_finish;
  end
endmodule // dsr_status_bench
